/* hdl/pmf_pkg.sv */
// Constants for the power mode and fetch trap controller.
// Assumes one clock domain, AHB-Lite register access, 32-bit data.
package pmf_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] PMF_CTRL_OFS   = 8'h00;
    localparam logic [7:0] PMF_STATUS_OFS = 8'h04;
    localparam logic [7:0] PMF_MODE_OFS   = 8'h08;
    localparam logic [7:0] PMF_FAULT_OFS  = 8'h0c;
    // Control bits
    localparam int PMF_CTRL_SBYF_BIT = 0;
    localparam int PMF_CTRL_RAM_EN_BIT = 1;
    localparam logic [1:0] PMF_CTRL_RESET = 2'h2;
    // ****************************************************************
    // Fetch trap ranges and vectors
    // ****************************************************************
    localparam logic [15:0] PMF_TRAP_VEC_HI  = 16'hffee;
    localparam logic [15:0] PMF_TRAP_VEC_LO  = 16'hffef;
    localparam logic [15:0] PMF_LOW_END_A    = 16'h001f;
    localparam logic [15:0] PMF_LOW_END_B    = 16'h003f;
    localparam logic [15:0] PMF_M5_HI_START  = 16'h0200;
    localparam logic [15:0] PMF_M7_HI_START  = 16'h0100;
    localparam logic [15:0] PMF_HI_END       = 16'hefff;
    localparam logic [15:0] PMF_PROG_TOP     = 16'h7fff;
    localparam logic [15:0] PMF_PROG_ROM_END = 16'h0fff;
    localparam logic [7:0]  PMF_PROG_BLANK   = 8'hff;
    localparam logic [2:0]  PMF_PROG_MODE    = 3'h3;
    // ****************************************************************
    // Power states
    // ****************************************************************
    typedef enum logic [3:0] {
        PMF_RESET   = 4'b0001,
        PMF_ACTIVE  = 4'b0010,
        PMF_SLEEP   = 4'b0100,
        PMF_STANDBY = 4'b1000
    } pmf_state_t;
endpackage

/* hdl/pmf_power_ctrl.sv */
// Power mode sequencer, fetch trap detector and pin state control.
// Assumes CPU core signals and pins synchronous to hclk; AHB-Lite slave.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module pmf_power_ctrl
    import pmf_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        standby_pin_n,
    input  wire logic        external_reset_input_n,
    input  wire logic        nmi_n,
    input  wire logic        irq_n,
    input  wire logic        irq_req,
    input  wire logic        irq_masked,
    input  wire logic        sleep_instruction,
    input  wire logic        opcode_fetch,
    input  wire logic        undefined_opcode,
    input  wire logic [15:0] fetch_addr,
    input  wire logic [2:0]  mode_pins,
    input  wire logic        crystal_input_pin,
    input  wire logic        prog_we,
    input  wire logic [15:0] prog_addr,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             cpu_reset,
    output logic             wake_vector,
    output logic             wake_resume,
    output logic             trap_req,
    output logic [15:0]      trap_vector,
    output logic             ram_retain,
    output logic             crystal_output_pin,
    output logic             crystal_output_oe,
    output logic             port_hold,
    output logic             port_oe_kill,
    output logic             addr_drive_high,
    output logic             data_float,
    output logic             rw_strobe_pin,
    output logic             rw_strobe_oe,
    output logic             prog_mode,
    output logic             prog_rom_we,
    output logic             prog_read_blank
);
    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic [1:0]  ctrl;
    logic        fault_seen;
    pmf_state_t  state;
    pmf_state_t  next_state;

    wire bus_req     = hsel && hready && htrans[1];
    wire wr_ctrl     = ap_valid && ap_write && (ap_addr == PMF_CTRL_OFS);
    wire wr_fault    = ap_valid && ap_write && (ap_addr == PMF_FAULT_OFS);
    wire rd_ctrl     = (haddr[7:0] == PMF_CTRL_OFS);
    wire rd_status   = (haddr[7:0] == PMF_STATUS_OFS);
    wire rd_mode     = (haddr[7:0] == PMF_MODE_OFS);
    wire rd_fault    = (haddr[7:0] == PMF_FAULT_OFS);
    wire bus_rd      = bus_req && !hwrite;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end
        else
        begin
            ap_valid <= bus_req;
            ap_write <= hwrite;
            ap_addr  <= haddr[7:0];
        end
    end

    // Read data registered at the address phase, zero when unmapped
    wire [31:0] next_hrdata =
        !bus_rd   ? 32'h0000_0000 :
        rd_ctrl   ? {30'h0, ctrl} :
        rd_status ? {28'h0, state} :
        rd_mode   ? {29'h0, mode_pins} :
        rd_fault  ? {31'h0, fault_seen} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ****************************************************************
    // RAM control register; hresetn is power-on, so flag survives cpu reset
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= PMF_CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= hwdata[1:0];
    end

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    // Standby overrides every other event; standby ignores reset and interrupts
    wire standby_pin_req = !standby_pin_n;
    wire wake_irq = irq_req;

    always_comb
    begin
        next_state = state;
        case (state)
            PMF_RESET:
                if (standby_pin_req)
                    next_state = PMF_STANDBY;
                else if (external_reset_input_n)
                    next_state = PMF_ACTIVE;
            PMF_ACTIVE:
                if (standby_pin_req)
                    next_state = PMF_STANDBY;
                else if (!external_reset_input_n)
                    next_state = PMF_RESET;
                else if (sleep_instruction)
                    next_state = PMF_SLEEP;
            PMF_SLEEP:
                if (standby_pin_req)
                    next_state = PMF_STANDBY;
                else if (!external_reset_input_n)
                    next_state = PMF_RESET;
                else if (wake_irq)
                    next_state = PMF_ACTIVE;
            PMF_STANDBY:
                if (!standby_pin_req)
                    next_state = PMF_RESET;
            default:
                next_state = PMF_RESET;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= PMF_RESET;
        else
            state <= next_state;
    end

    // ****************************************************************
    // Fetch trap detection
    // ****************************************************************
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Unpopulated external space maps as usable and is never flagged
    wire low_a   = in_range(fetch_addr, 16'h0000, PMF_LOW_END_A);
    wire low_b   = in_range(fetch_addr, 16'h0000, PMF_LOW_END_B);
    wire illegal =
        (mode_pins == 3'h5) ? (low_b || in_range(fetch_addr, PMF_M5_HI_START, PMF_HI_END)) :
        (mode_pins == 3'h7) ? (low_b || in_range(fetch_addr, PMF_M7_HI_START, PMF_HI_END)) :
        (mode_pins == 3'h0 || mode_pins == 3'h1 || mode_pins == 3'h2 || mode_pins == 3'h6)
                            ? low_a : 1'b0;
    wire fetch_fault = (state == PMF_ACTIVE) && opcode_fetch &&
                       (undefined_opcode || illegal);

    // Fault flag: set wins over software clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fault_seen <= 1'b0;
        else if (fetch_fault)
            fault_seen <= 1'b1;
        else if (wr_fault && hwdata[0])
            fault_seen <= 1'b0;
    end

    // ****************************************************************
    // Outputs, all registered; trap outputs from fetch_fault, others from next state or fixed
    // ****************************************************************
    wire n_sleep = (next_state == PMF_SLEEP);
    wire n_standby_pin  = (next_state == PMF_STANDBY);
    wire n_rst   = (next_state == PMF_RESET);
    wire n_prog  = n_standby_pin && (mode_pins == PMF_PROG_MODE) && !nmi_n &&
                   crystal_input_pin;
    wire wake    = (state == PMF_SLEEP) && (next_state == PMF_ACTIVE);
    wire n_mux_d = (mode_pins == 3'h0 || mode_pins == 3'h2 || mode_pins == 3'h6);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cpu_clk_en         <= 1'b0;
            periph_clk_en      <= 1'b0;
            cpu_reset          <= 1'b1;
            wake_vector        <= 1'b0;
            wake_resume        <= 1'b0;
            trap_req           <= 1'b0;
            trap_vector        <= PMF_TRAP_VEC_HI;
            ram_retain         <= 1'b1;
            crystal_output_pin <= 1'b1;
            crystal_output_oe  <= 1'b1;
            port_hold          <= 1'b0;
            port_oe_kill       <= 1'b1;
            addr_drive_high    <= 1'b0;
            data_float         <= 1'b1;
            rw_strobe_pin      <= 1'b1;
            rw_strobe_oe       <= 1'b1;
            prog_mode          <= 1'b0;
            prog_rom_we        <= 1'b0;
            prog_read_blank    <= 1'b0;
        end
        else
        begin
            cpu_clk_en         <= (next_state == PMF_ACTIVE);
            periph_clk_en      <= !n_standby_pin && !n_rst;
            cpu_reset          <= n_rst || n_standby_pin;
            wake_vector        <= wake && !irq_masked;
            wake_resume        <= wake && irq_masked;
            trap_req           <= fetch_fault;
            trap_vector        <= fetch_fault ? PMF_TRAP_VEC_HI : PMF_TRAP_VEC_LO;
            ram_retain         <= 1'b1;
            crystal_output_pin <= 1'b1;
            crystal_output_oe  <= !n_prog;
            port_hold          <= n_sleep;
            port_oe_kill       <= n_standby_pin || (n_rst && n_mux_d);
            addr_drive_high    <= n_sleep;
            data_float         <= !(next_state == PMF_ACTIVE);
            rw_strobe_pin      <= 1'b1;
            rw_strobe_oe       <= !n_standby_pin && (!n_rst || n_mux_d || mode_pins == 3'h7);
            prog_mode          <= n_prog;
            prog_rom_we        <= n_prog && prog_we && (prog_addr <= PMF_PROG_ROM_END);
            prog_read_blank    <= n_prog && (prog_addr > PMF_PROG_ROM_END) &&
                                  (prog_addr <= PMF_PROG_TOP);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_sleep_gate;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_ACTIVE && sleep_instruction && standby_pin_n && external_reset_input_n)
            |=> !cpu_clk_en && periph_clk_en;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("sleep did not gate cpu clock");

    property p_periph_run;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_SLEEP) |-> periph_clk_en;
    endproperty
    a_periph_run: assert property (p_periph_run) else $error("peripheral clock stopped in sleep");

    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_SLEEP && irq_req && standby_pin_n && external_reset_input_n && !irq_masked)
            |=> wake_vector && cpu_clk_en;
    endproperty
    a_wake: assert property (p_wake) else $error("accepted interrupt did not vector");

    property p_resume;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_SLEEP && irq_req && irq_masked && standby_pin_n && external_reset_input_n)
            |=> wake_resume && !wake_vector;
    endproperty
    a_resume: assert property (p_resume) else $error("masked wake did not resume");

    property p_no_req;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_SLEEP && !irq_req && standby_pin_n && external_reset_input_n)
            |=> state == PMF_SLEEP;
    endproperty
    a_no_req: assert property (p_no_req) else $error("sleep left without request");

    property p_standby_pin;
        @(posedge hclk) disable iff (!hresetn)
        !standby_pin_n |=> cpu_reset && !periph_clk_en && crystal_output_pin && port_oe_kill;
    endproperty
    a_standby_pin: assert property (p_standby_pin) else $error("standby entry wrong");

    property p_standby_pin_exit;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_STANDBY) |=> (state == PMF_STANDBY || state == PMF_RESET);
    endproperty
    a_standby_pin_exit: assert property (p_standby_pin_exit) else $error("standby left without reset");

    property p_trap;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_ACTIVE && opcode_fetch && mode_pins == 3'h0 && fetch_addr == 16'h001f)
            |=> trap_req && trap_vector == PMF_TRAP_VEC_HI;
    endproperty
    a_trap: assert property (p_trap) else $error("illegal fetch not trapped");

    property p_data_ok;
        @(posedge hclk) disable iff (!hresetn)
        (!opcode_fetch) |=> !trap_req;
    endproperty
    a_data_ok: assert property (p_data_ok) else $error("data access trapped");

    property p_sleep_pins;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_SLEEP) |-> port_hold && addr_drive_high && data_float && rw_strobe_pin;
    endproperty
    a_sleep_pins: assert property (p_sleep_pins) else $error("sleep pin state wrong");

    property p_standby_pin_hold;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_STANDBY && !standby_pin_n) |=> state == PMF_STANDBY && cpu_reset && !cpu_clk_en;
    endproperty
    a_standby_pin_hold: assert property (p_standby_pin_hold) else $error("standby left while pin held low");

    property p_reset_pins;
        @(posedge hclk) disable iff (!hresetn)
        (!external_reset_input_n && standby_pin_n && (mode_pins == 3'h0 || mode_pins == 3'h2 || mode_pins == 3'h6))
            |=> cpu_reset && port_oe_kill && rw_strobe_pin && rw_strobe_oe;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("reset pin state wrong");

    property p_prog_map;
        @(posedge hclk) disable iff (!hresetn)
        (!standby_pin_n && mode_pins == PMF_PROG_MODE && !nmi_n && crystal_input_pin && prog_we &&
         prog_addr > PMF_PROG_ROM_END && prog_addr <= PMF_PROG_TOP)
            |=> prog_mode && !prog_rom_we && prog_read_blank;
    endproperty
    a_prog_map: assert property (p_prog_map) else $error("programming write above rom not ignored");

    property p_opcode_trap;
        @(posedge hclk) disable iff (!hresetn)
        (state == PMF_ACTIVE && opcode_fetch && undefined_opcode) |=> trap_req && trap_vector == PMF_TRAP_VEC_HI;
    endproperty
    a_opcode_trap: assert property (p_opcode_trap) else $error("undefined opcode not trapped");
endmodule

/* dv/pmf_sys_model.sv */
// System-side model: standby, reset, interrupt, mode and crystal pins.
// Assumes the bench calls its tasks from one process, right after an edge.
`timescale 1ns/1ps
module pmf_sys_model
(
    input  wire logic       hclk,
    output logic            standby_pin_n,
    output logic            external_reset_input_n,
    output logic            nmi_n,
    output logic            irq_n,
    output logic            irq_req,
    output logic            crystal_input_pin,
    output logic [2:0]      mode_pins
);
    // ********************
    // Pin drivers
    // ********************
    // Idle pattern: no standby, no reset, no interrupt
    initial
    begin
        standby_pin_n = 1'b1;
        external_reset_input_n = 1'b1;
        nmi_n = 1'b1;
        irq_n = 1'b1;
        irq_req = 1'b0;
        crystal_input_pin = 1'b1; // High keeps standby current low
        mode_pins = 3'h0;
    end
    // Change every pin but the crystal input just after one edge
    task automatic drive(input logic sb, input logic rs, input logic nm, input logic rq, input logic [2:0] md);
    begin
        @(posedge hclk);
        standby_pin_n <= sb;
        external_reset_input_n <= rs;
        nmi_n <= nm;
        irq_req <= rq;
        irq_n <= ~rq;
        mode_pins <= md;
    end
    endtask
    // Standby is only left through a reset start
    task automatic leave_standby(input logic [2:0] md);
    begin
        drive(1'b1, 1'b0, 1'b1, 1'b0, md);
        repeat (3) @(posedge hclk);
        drive(1'b1, 1'b1, 1'b1, 1'b0, md);
    end
    endtask
    // Programming entry: standby low, mode pins 0/1 high, 2 low, nmi low
    task automatic enter_prog;
        drive(1'b0, 1'b1, 1'b0, 1'b0, 3'h3);
    endtask
endmodule

/* dv/test_power_mode_and_fetch_trap.sv */
// Self-checking bench for the power mode and fetch trap controller.
// Assumes pmf_sys_model drives the system pins; the bench is the bus master.
`timescale 1ns/1ps
module test_power_mode_and_fetch_trap
    import pmf_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_masked, sleep_instruction;
    logic        standby_pin_n, external_reset_input_n, nmi_n, irq_n, irq_req, crystal_input_pin;
    logic        opcode_fetch, undefined_opcode, prog_we, cpu_clk_en, periph_clk_en, cpu_reset;
    logic        wake_vector, wake_resume, trap_req, ram_retain, crystal_output_pin, crystal_output_oe;
    logic        port_hold, port_oe_kill, addr_drive_high, data_float, rw_strobe_pin, rw_strobe_oe;
    logic        prog_mode, prog_rom_we, prog_read_blank;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, mode_pins;
    logic [15:0] fetch_addr, prog_addr, trap_vector, last_vec;
    int          fail_count, n_tests, n_trap, n_vec, n_res;
    // Trap table: {mode, trap expected, fetch address}
    logic [19:0] tbl [16] = '{20'h1001f, 20'h00020, 20'h30000, 20'h5001f, 20'hd0010, 20'hb003f,
                              20'ha0040, 20'hb0200, 20'hbefff, 20'haf000, 20'ha01ff, 20'hf0100,
                              20'he00ff, 20'hfefff, 20'h60000, 20'h80010};
    assign hready = hreadyout;
    pmf_sys_model sys (.hclk(hclk), .standby_pin_n(standby_pin_n), .external_reset_input_n(external_reset_input_n),
        .nmi_n(nmi_n), .irq_n(irq_n), .irq_req(irq_req), .crystal_input_pin(crystal_input_pin), .mode_pins(mode_pins));
    pmf_power_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .standby_pin_n(standby_pin_n), .external_reset_input_n(external_reset_input_n),
        .nmi_n(nmi_n), .irq_n(irq_n), .irq_req(irq_req), .irq_masked(irq_masked),
        .sleep_instruction(sleep_instruction), .opcode_fetch(opcode_fetch), .undefined_opcode(undefined_opcode),
        .fetch_addr(fetch_addr), .mode_pins(mode_pins), .crystal_input_pin(crystal_input_pin), .prog_we(prog_we),
        .prog_addr(prog_addr), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .cpu_reset(cpu_reset),
        .wake_vector(wake_vector), .wake_resume(wake_resume), .trap_req(trap_req), .trap_vector(trap_vector),
        .ram_retain(ram_retain), .crystal_output_pin(crystal_output_pin), .crystal_output_oe(crystal_output_oe),
        .port_hold(port_hold), .port_oe_kill(port_oe_kill), .addr_drive_high(addr_drive_high),
        .data_float(data_float), .rw_strobe_pin(rw_strobe_pin), .rw_strobe_oe(rw_strobe_oe),
        .prog_mode(prog_mode), .prog_rom_we(prog_rom_we), .prog_read_blank(prog_read_blank));
    // ********************
    // Shared tasks
    // ********************
    // Clock, 4 ns period
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // Count one-cycle pulses so none is missed between checks
    always @(posedge hclk)
    begin
        if (trap_req === 1'b1)
            last_vec = trap_vector;
        n_trap += (trap_req === 1'b1);
        n_vec += (wake_vector === 1'b1);
        n_res += (wake_resume === 1'b1);
    end
    task automatic final_report;
    begin
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    end
    endtask
    task automatic settle;
        repeat (3) @(posedge hclk);
    endtask
    // Wait for hready high at an edge, bounded
    task automatic wait_rdy;
    begin
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
            chk("hready", 1, 0);
    end
    endtask
    // One single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    begin
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
        chk("hresp", 0, hresp);
    end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    begin
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    end
    endtask
    task automatic do_sleep;
    begin
        @(posedge hclk);
        sleep_instruction <= 1'b1;
        @(posedge hclk);
        sleep_instruction <= 1'b0;
        settle;
    end
    endtask
    // One opcode fetch; returns the number of traps raised
    task automatic fetch(input logic [15:0] a, input logic u, output int d);
    begin
        d = n_trap;
        @(posedge hclk);
        opcode_fetch <= 1'b1;
        fetch_addr <= a;
        undefined_opcode <= u;
        @(posedge hclk);
        opcode_fetch <= 1'b0;
        undefined_opcode <= 1'b0;
        settle;
        d = n_trap - d;
    end
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_regs;
    begin
        rchk("ctrl", PMF_CTRL_OFS, 32'h2);
        rchk("status", PMF_STATUS_OFS, 32'h2);
        bus(1'b1, PMF_MODE_OFS, 32'hff);
        rchk("mode", PMF_MODE_OFS, 32'h0);
        bus(1'b1, 8'h10, 32'hffff_ffff);
        rchk("unmapped", 8'h10, 32'h0);
    end
    endtask
    task automatic t_sleep;
    begin
        int v;
        int r;
        do_sleep;
        chk("cpu_clk_en", 0, cpu_clk_en);
        chk("periph_clk_en", 1, periph_clk_en);
        chk("port_hold", 1, port_hold);
        chk("addr_drive_high", 1, addr_drive_high);
        chk("data_float", 1, data_float);
        chk("rw_strobe_pin", 1, rw_strobe_pin);
        repeat (8) @(posedge hclk);
        rchk("status", PMF_STATUS_OFS, 32'h4);
        v = n_vec;
        r = n_res;
        irq_masked <= 1'b1;
        sys.drive(1'b1, 1'b1, 1'b1, 1'b1, 3'h0);
        sys.drive(1'b1, 1'b1, 1'b1, 1'b0, 3'h0);
        settle;
        chk("wake_resume", r + 1, n_res);
        chk("wake_vector", v, n_vec);
        chk("cpu_clk_en", 1, cpu_clk_en);
        irq_masked <= 1'b0;
        do_sleep;
        sys.drive(1'b1, 1'b1, 1'b1, 1'b1, 3'h0);
        sys.drive(1'b1, 1'b1, 1'b1, 1'b0, 3'h0);
        settle;
        chk("wake_vector", v + 1, n_vec);
        do_sleep;
        sys.drive(1'b1, 1'b0, 1'b1, 1'b0, 3'h0);
        settle;
        chk("cpu_reset", 1, cpu_reset);
        rchk("status", PMF_STATUS_OFS, 32'h1);
        sys.drive(1'b1, 1'b1, 1'b1, 1'b0, 3'h0);
        do_sleep;
        sys.drive(1'b0, 1'b1, 1'b1, 1'b1, 3'h0);
        settle;
        rchk("status", PMF_STATUS_OFS, 32'h8);
        sys.leave_standby(3'h0);
        settle;
        rchk("status", PMF_STATUS_OFS, 32'h2);
    end
    endtask
    task automatic t_standby;
    begin
        bus(1'b1, PMF_CTRL_OFS, 32'h1);
        sys.drive(1'b0, 1'b1, 1'b1, 1'b0, 3'h0);
        settle;
        chk("cpu_reset", 1, cpu_reset);
        chk("cpu_clk_en", 0, cpu_clk_en);
        chk("periph_clk_en", 0, periph_clk_en);
        chk("ram_retain", 1, ram_retain);
        chk("crystal_output_pin", 1, crystal_output_pin);
        chk("port_oe_kill", 1, port_oe_kill);
        chk("data_float", 1, data_float);
        sys.drive(1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
        settle;
        rchk("status", PMF_STATUS_OFS, 32'h8);
        sys.leave_standby(3'h0);
        settle;
        rchk("status", PMF_STATUS_OFS, 32'h2);
        rchk("ctrl", PMF_CTRL_OFS, 32'h1);
    end
    endtask
    task automatic t_trap;
    begin
        int d;
        for (int i = 0; i < 16; i++)
        begin
            sys.drive(1'b1, 1'b1, 1'b1, 1'b0, tbl[i][19:17]);
            fetch(tbl[i][15:0], 1'b0, d);
            chk("trap_count", {31'h0, tbl[i][16]}, d);
        end
        sys.drive(1'b1, 1'b1, 1'b1, 1'b0, 3'h0);
        d = n_trap;
        @(posedge hclk);
        fetch_addr <= 16'h0000;
        settle;
        chk("trap_count", 0, n_trap - d);
        fetch(16'h1000, 1'b1, d);
        chk("trap_count", 1, d);
        chk("trap_vector", PMF_TRAP_VEC_HI, last_vec);
        rchk("fault", PMF_FAULT_OFS, 32'h1);
        bus(1'b1, PMF_FAULT_OFS, 32'h1);
        rchk("fault", PMF_FAULT_OFS, 32'h0);
    end
    endtask
    task automatic t_prog;
    begin
        sys.enter_prog;
        settle;
        chk("prog_mode", 1, prog_mode);
        chk("crystal_output_oe", 0, crystal_output_oe);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge hclk);
            prog_we <= (i < 2);
            prog_addr <= (i == 0) ? 16'h0fff : (i == 1) ? 16'h1000 : 16'h7fff;
            settle;
            chk("prog_rom_we", (i == 0), prog_rom_we);
            chk("prog_read_blank", (i > 0), prog_read_blank);
        end
        prog_we <= 1'b0;
        sys.leave_standby(3'h0);
        settle;
    end
    endtask
    // ********************
    // Main sequence and watchdog
    // ********************
    initial
    begin
        {hresetn, hsel, hwrite, irq_masked, sleep_instruction, opcode_fetch, undefined_opcode, prog_we} = '0;
        {haddr, hwdata, htrans, fetch_addr, prog_addr} = '0;
        hsize = 3'b010;
        repeat (4) @(posedge hclk);
        chk("cpu_reset", 1, cpu_reset);
        chk("port_oe_kill", 1, port_oe_kill);
        chk("rw_strobe_pin", 1, rw_strobe_pin);
        chk("rw_strobe_oe", 1, rw_strobe_oe);
        @(posedge hclk);
        hresetn <= 1'b1;
        settle;
        t_regs;
        t_sleep;
        t_standby;
        t_trap;
        t_prog;
        final_report;
    end
    initial
    begin
        #20000;
        fail_count++;
        final_report;
    end
endmodule
